/* File: core/bxd_decoder.sv */
/*
 * Decoder and executor for one instruction group of an 8-bit core.
 * Assumes the fetch unit presents the next instruction word steadily
 * across a whole cycle, and the register file answers reads
 * combinationally within the cycle.
 */
`timescale 1ns/100ps
`default_nettype none
module bxd_decoder (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // instruction fetch
    input wire logic [13:0] insn,
    input wire logic [12:0] pc_cur,
    output logic insn_done,
    output logic flush,
    // register file
    output logic [6:0] reg_addr,
    input wire logic [7:0] reg_rdata,
    output logic reg_we,
    output logic [7:0] reg_wdata,
    // stack and program counter
    input wire logic [12:0] stack_top,
    output logic stack_pop,
    output logic stack_push,
    output logic [12:0] stack_push_data,
    output logic pc_load,
    output logic [12:0] pc_load_data,
    // interrupt request
    input wire logic irq_req,
    // status and state
    output logic zero_we,
    output logic zero_val,
    output logic [7:0] w_out,
    output logic [7:0] option_out,
    output logic [7:0] irq_control_reg,
    output logic global_irq_enable
);
    // ************************************************************
    // phase and decode
    // ************************************************************
    bxd_pkg::bxd_phase_t phase_r;
    bxd_pkg::bxd_op_t op_r;
    logic [13:0] insn_r;
    logic idle_r;
    logic [7:0] opnd_r;
    logic [7:0] result_r;
    logic [7:0] w_r;
    logic [7:0] option_r;
    logic [7:0] irqctl_r;
    logic irq_take;
    bxd_pkg::bxd_op_t op_nxt;
    logic [2:0] bit_idx;
    logic [7:0] bit_mask;
    logic dest_f;
    logic bit_val;

    assign bit_idx = insn_r[bxd_pkg::BIT_LSB +: bxd_pkg::BIT_W];
    assign bit_mask = 8'h01 << bit_idx;
    assign dest_f = insn_r[bxd_pkg::DEST_BIT];
    assign bit_val = |(opnd_r & bit_mask);
    // no irq in return or idle
    assign irq_take = irq_req & irqctl_r[bxd_pkg::GIE_BIT] & ~idle_r &
        (op_r != bxd_pkg::OP_RETI);

    always_comb begin
        op_nxt = bxd_pkg::OP_NONE;
        if ((insn & bxd_pkg::NOP_MASK) == bxd_pkg::NOP_CODE) begin
            op_nxt = bxd_pkg::OP_NONE;
        end else if (insn == bxd_pkg::RET_IRQ_CODE) begin
            op_nxt = bxd_pkg::OP_RETI;
        end else if (insn == bxd_pkg::OPTION_LOAD_CODE) begin
            op_nxt = bxd_pkg::OP_OPTN;
        end else if (insn[13:10] == bxd_pkg::OPC_BIT_CLEAR) begin
            op_nxt = bxd_pkg::OP_BCLR;
        end else if (insn[13:10] == bxd_pkg::OPC_BIT_SET) begin
            op_nxt = bxd_pkg::OP_BSET;
        end else if (insn[13:10] == bxd_pkg::OPC_TEST_SKIP) begin
            op_nxt = bxd_pkg::OP_BTST;
        end else if (insn[13:8] == bxd_pkg::OPC_XOR_LIT) begin
            op_nxt = bxd_pkg::OP_XORL;
        end else if (insn[13:8] == bxd_pkg::OPC_XOR_REG) begin
            op_nxt = bxd_pkg::OP_XORF;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= bxd_pkg::PH_Q1;
        end else begin
            case (phase_r)
                bxd_pkg::PH_Q1: phase_r <= bxd_pkg::PH_Q2;
                bxd_pkg::PH_Q2: phase_r <= bxd_pkg::PH_Q3;
                bxd_pkg::PH_Q3: phase_r <= bxd_pkg::PH_Q4;
                bxd_pkg::PH_Q4: phase_r <= bxd_pkg::PH_Q1;
                default: phase_r <= bxd_pkg::PH_Q1;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            insn_r <= 14'h0000;
            op_r <= bxd_pkg::OP_NONE;
        end else if (phase_r == bxd_pkg::PH_Q1) begin
            insn_r <= insn;
            op_r <= idle_r ? bxd_pkg::OP_NONE : op_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_r <= 1'b0;
        end else if (phase_r == bxd_pkg::PH_Q4) begin
            idle_r <= (op_r == bxd_pkg::OP_RETI) || irq_take ||
                ((op_r == bxd_pkg::OP_BTST) && !bit_val);
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            opnd_r <= 8'h00;
        end else if (phase_r == bxd_pkg::PH_Q2) begin
            opnd_r <= (op_r == bxd_pkg::OP_XORL) ?
                insn_r[bxd_pkg::LIT_LSB +: bxd_pkg::DATA_W] : reg_rdata;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            result_r <= 8'h00;
        end else if (phase_r == bxd_pkg::PH_Q3) begin
            case (op_r)
                bxd_pkg::OP_BCLR: result_r <= opnd_r & ~bit_mask;
                bxd_pkg::OP_BSET: result_r <= opnd_r | bit_mask;
                bxd_pkg::OP_XORL: result_r <= opnd_r ^ w_r;
                bxd_pkg::OP_XORF: result_r <= opnd_r ^ w_r;
                default: result_r <= opnd_r;
            endcase
        end
    end

    // ************************************************************
    // state registers
    // ************************************************************
    // working register write in Q4
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            w_r <= bxd_pkg::W_RESET;
        end else if (phase_r == bxd_pkg::PH_Q4) begin
            if (op_r == bxd_pkg::OP_XORL ||
                (op_r == bxd_pkg::OP_XORF && !dest_f)) begin
                w_r <= result_r;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            option_r <= bxd_pkg::OPTION_RESET;
        end else if (phase_r == bxd_pkg::PH_Q4 &&
                     op_r == bxd_pkg::OP_OPTN) begin
            option_r <= w_r;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            irqctl_r <= bxd_pkg::IRQCTL_RESET;
        end else if (phase_r == bxd_pkg::PH_Q3 &&
                     op_r == bxd_pkg::OP_RETI) begin
            irqctl_r[bxd_pkg::GIE_BIT] <= 1'b1;
        end else if (phase_r == bxd_pkg::PH_Q4 && irq_take) begin
            irqctl_r[bxd_pkg::GIE_BIT] <= 1'b0;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    logic q4;
    assign q4 = (phase_r == bxd_pkg::PH_Q4);
    assign reg_addr = insn_r[bxd_pkg::ADDR_LSB +: bxd_pkg::ADDR_W];
    assign reg_we = q4 && (op_r == bxd_pkg::OP_BCLR ||
        op_r == bxd_pkg::OP_BSET || (op_r == bxd_pkg::OP_XORF && dest_f));
    assign reg_wdata = result_r;
    assign zero_we = q4 && (op_r == bxd_pkg::OP_XORL ||
        op_r == bxd_pkg::OP_XORF);
    assign zero_val = (result_r == 8'h00);
    assign stack_pop = q4 && (op_r == bxd_pkg::OP_RETI);
    assign stack_push = q4 && irq_take;
    assign stack_push_data = pc_cur;
    assign pc_load = stack_pop || stack_push;
    assign pc_load_data = stack_pop ? stack_top : bxd_pkg::IRQ_VECTOR;
    assign flush = q4 && ((op_r == bxd_pkg::OP_BTST && !bit_val) ||
        op_r == bxd_pkg::OP_RETI || irq_take);
    assign insn_done = q4;
    assign w_out = w_r;
    assign option_out = option_r;
    assign irq_control_reg = irqctl_r;
    assign global_irq_enable = irqctl_r[bxd_pkg::GIE_BIT];

    // ************************************************************
    // checks
    // ************************************************************
    property p_clear_bit;
        @(posedge sys_clk) disable iff (!reset_n)
        (reg_we && op_r == bxd_pkg::OP_BCLR) |-> !reg_wdata[bit_idx];
    endproperty
    a_clear_bit: assert property (p_clear_bit)
        else $error("clear bit set");
    property p_set_bit;
        @(posedge sys_clk) disable iff (!reset_n)
        (reg_we && op_r == bxd_pkg::OP_BSET) |-> reg_wdata[bit_idx];
    endproperty
    a_set_bit: assert property (p_set_bit)
        else $error("set bit clear");
    property p_skip_idle;
        @(posedge sys_clk) disable iff (!reset_n)
        (q4 && op_r == bxd_pkg::OP_BTST && !bit_val) |=> ##1 idle_r;
    endproperty
    a_skip_idle: assert property (p_skip_idle)
        else $error("no skip");
    property p_nop_quiet;
        @(posedge sys_clk) disable iff (!reset_n)
        (op_r == bxd_pkg::OP_NONE) |-> !reg_we && !zero_we && !stack_pop &&
            (pc_load == stack_push);
    endproperty
    a_nop_quiet: assert property (p_nop_quiet)
        else $error("nop acts");
    property p_reti_gie;
        @(posedge sys_clk) disable iff (!reset_n)
        (phase_r == bxd_pkg::PH_Q3 && op_r == bxd_pkg::OP_RETI)
        |=> global_irq_enable && stack_pop;
    endproperty
    a_reti_gie: assert property (p_reti_gie)
        else $error("reti wrong");
    property p_option;
        @(posedge sys_clk) disable iff (!reset_n)
        (q4 && op_r == bxd_pkg::OP_OPTN) |=> option_r == $past(w_r);
    endproperty
    a_option: assert property (p_option)
        else $error("option lost");
    property p_xorl;
        @(posedge sys_clk) disable iff (!reset_n)
        (phase_r == bxd_pkg::PH_Q3 && op_r == bxd_pkg::OP_XORL)
        |=> ##1 w_r == $past(opnd_r ^ w_r, 2);
    endproperty
    a_xorl: assert property (p_xorl)
        else $error("xor literal bad");
    property p_xorf_dest;
        @(posedge sys_clk) disable iff (!reset_n)
        (q4 && op_r == bxd_pkg::OP_XORF) |-> reg_we == dest_f && zero_we;
    endproperty
    a_xorf_dest: assert property (p_xorf_dest)
        else $error("dest wrong");
    property p_phase;
        @(posedge sys_clk) disable iff (!reset_n)
        q4 |=> phase_r == bxd_pkg::PH_Q1 ##3 q4;
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase order");
    property p_vector;
        @(posedge sys_clk) disable iff (!reset_n)
        stack_push |-> pc_load_data == bxd_pkg::IRQ_VECTOR ##1
        !global_irq_enable;
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector bad");
    c_skip: cover property (@(posedge sys_clk) flush && !stack_pop);
    c_xorf_reg: cover property (@(posedge sys_clk)
        reg_we && op_r == bxd_pkg::OP_XORF);
    c_option: cover property (@(posedge sys_clk) q4 && op_r == bxd_pkg::OP_OPTN);
    c_reti: cover property (@(posedge sys_clk) stack_pop);
    c_irq: cover property (@(posedge sys_clk) stack_push);
endmodule : bxd_decoder
`default_nettype wire

/* File: core/bxd_pkg.sv */
/*
 * Constants for the bit, skip, xor and return instruction decoder.
 * Assumes a 14-bit instruction word and an 8-bit data path.
 */
package bxd_pkg;
    // ************************************************************
    // instruction fields
    // ************************************************************
    localparam int INSN_W = 14;
    localparam int ADDR_W = 7;
    localparam int BIT_W = 3;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int ADDR_LSB = 0;
    localparam int BIT_LSB = 7;
    localparam int DEST_BIT = 7;
    localparam int LIT_LSB = 0;
    localparam int GIE_BIT = 7;
    // ************************************************************
    // opcode patterns
    // ************************************************************
    localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
    localparam logic [3:0] OPC_BIT_SET = 4'h5;
    localparam logic [3:0] OPC_TEST_SKIP = 4'h6;
    localparam logic [5:0] OPC_XOR_LIT = 6'h3A;
    localparam logic [5:0] OPC_XOR_REG = 6'h06;
    localparam logic [13:0] NOP_MASK = 14'h3F9F;
    localparam logic [13:0] NOP_CODE = 14'h0000;
    localparam logic [13:0] RET_IRQ_CODE = 14'h0009;
    localparam logic [13:0] OPTION_LOAD_CODE = 14'h0062;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;
    localparam logic [7:0] OPTION_RESET = 8'hFF;
    localparam logic [7:0] IRQCTL_RESET = 8'h00;
    localparam logic [7:0] W_RESET = 8'h00;
    // ************************************************************
    // phase and operation kinds
    // ************************************************************
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b10,
        PH_Q4 = 2'b11
    } bxd_phase_t;
    typedef enum logic [2:0] {
        OP_NONE = 3'b000,
        OP_BCLR = 3'b001,
        OP_BSET = 3'b010,
        OP_BTST = 3'b011,
        OP_RETI = 3'b100,
        OP_OPTN = 3'b101,
        OP_XORL = 3'b110,
        OP_XORF = 3'b111
    } bxd_op_t;
endpackage : bxd_pkg

/* File: testbench/bxd_partner.sv */
/*
 * Partner model: data register file and stack top.
 * Assumes one clock, combinational reads and Q4 write pulses.
 */
`timescale 1ns/100ps
`default_nettype none
module bxd_partner (
    // clock
    input wire logic sys_clk,
    // register file
    input wire logic [6:0] reg_addr,
    input wire logic reg_we,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // stack
    input wire logic stack_push,
    input wire logic [12:0] stack_push_data,
    output logic [12:0] stack_top
);
    logic [7:0] mem_r [128];
    logic [12:0] top_r = 13'h0123;
    assign stack_top = top_r;
    // preset contents: address xor A5
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem_r[i] = 8'(i) ^ 8'hA5;
        end
    end
    assign reg_rdata = mem_r[reg_addr];
    always @(posedge sys_clk) begin
        if (reg_we) begin
            mem_r[reg_addr] <= reg_wdata;
        end
        if (stack_push) begin
            top_r <= stack_push_data;
        end
    end
endmodule : bxd_partner
`default_nettype wire

/* File: testbench/bxd_tb_top.sv */
/*
 * Testbench for the instruction group decoder.
 * Assumes one instruction every four clocks, Q1 first after reset.
 */
`timescale 1ns/100ps
`default_nettype none
module bxd_tb_top;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [13:0] insn = 14'h0000;
    logic [12:0] pc_cur = 13'h0ABC;
    logic irq_req = 1'b0;
    logic insn_done, flush, reg_we, stack_pop, stack_push, pc_load;
    logic zero_we, zero_val, global_irq_enable;
    logic [6:0] reg_addr;
    logic [7:0] reg_rdata, reg_wdata, w_out, option_out, irq_control_reg;
    logic [12:0] stack_top, stack_push_data, pc_load_data;
    logic [8:0] fl;
    logic [7:0] wd, wo, op;
    logic [12:0] pd, sp;
    logic [6:0] ra;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;

    always #5 sys_clk = ~sys_clk;

    bxd_decoder bxd_decoder_inst (.sys_clk, .reset_n, .insn, .pc_cur,
        .insn_done, .flush, .reg_addr, .reg_rdata, .reg_we, .reg_wdata,
        .stack_top, .stack_pop, .stack_push, .stack_push_data, .pc_load,
        .pc_load_data, .irq_req, .zero_we, .zero_val, .w_out, .option_out,
        .irq_control_reg, .global_irq_enable);
    bxd_partner bxd_partner_inst (.sys_clk, .reg_addr, .reg_we, .reg_wdata,
        .reg_rdata, .stack_push, .stack_push_data, .stack_top);

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // flags: done we zwe zval flush pop push load enable
    task exec(input logic [13:0] w);
        insn <= w;
        repeat (3) @(posedge sys_clk);
        #1;
        fl = {insn_done, reg_we, zero_we, zero_val, flush, stack_pop,
              stack_push, pc_load, global_irq_enable};
        wd = reg_wdata;
        ra = reg_addr;
        pd = pc_load_data;
        sp = stack_push_data;
        wo = w_out;
        op = option_out;
        @(posedge sys_clk);
    endtask : exec

    task t_bits;
        exec(14'h13FF);
        chk("bclr", 9'h180, fl);
        chk("bclr data", 8'h5A, wd);
        chk("bclr addr", 7'h7F, ra);
        exec(14'h1480);
        chk("bset", 9'h180, fl);
        chk("bset data", 8'hA7, wd);
        chk("bset addr", 7'h00, ra);
    endtask : t_bits

    task t_xor;
        exec(14'h3AFF);
        chk("xorl", 9'h140, fl);
        exec(14'h3AFF);
        chk("xorl zero", 9'h160, fl);
        chk("w", 8'hFF, wo);
        exec(14'h3A3C);
        chk("w", 8'h00, wo);
        exec(14'h0690);
        chk("xorf d1", 9'h1C0, fl);
        chk("xorf data", 8'h89, wd);
        chk("w", 8'h3C, wo);
        exec(14'h0611);
        chk("xorf d0", 9'h140, fl);
        exec(14'h0062);
        chk("option", 9'h100, fl);
        chk("w", 8'h88, wo);
        exec(14'h0000);
        chk("option val", 8'h88, op);
    endtask : t_xor

    task t_nop;
        for (int i = 0; i < 4; i++) begin
            exec(14'(i * 32));
            chk("nop", 9'h100, fl);
            chk("w", 8'h88, wo);
        end
    endtask : t_nop

    task t_skip;
        exec(14'h1BFF);
        chk("skip", 9'h110, fl);
        exec(14'h3AFF);
        chk("idle", 7'h00, fl[7:1]);
        exec(14'h0000);
        chk("w", 8'h88, wo);
        exec(14'h1880);
        chk("no skip", 9'h100, fl);
    endtask : t_skip

    task t_reti;
        exec(14'h0009);
        chk("reti", 9'h11B, fl);
        chk("pop pc", 13'h0123, pd);
        exec(14'h3AFF);
        chk("idle", 7'h00, fl[7:1]);
        chk("ctl", 8'h80, irq_control_reg);
    endtask : t_reti

    task t_irq;
        irq_req <= 1'b1;
        exec(14'h0000);
        chk("irq", 8'h8B, fl[8:1]);
        chk("vector", 13'h0004, pd);
        chk("push", 13'h0ABC, sp);
        irq_req <= 1'b0;
        exec(14'h0000);
        chk("ctl", 8'h00, irq_control_reg);
        exec(14'h0009);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        chk("enable rst", 1'b0, global_irq_enable);
        chk("option rst", 8'hFF, option_out);
        chk("w rst", 8'h00, w_out);
        @(posedge sys_clk);
        reset_n <= 1'b1;
        exec(14'h3A5A);
        chk("xorl after rst", 9'h140, fl);
    endtask : t_irq

    task end_of_test;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            n_errors++;
            end_of_test;
        end
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_bits;
        t_xor;
        t_nop;
        t_skip;
        t_reti;
        t_irq;
        end_of_test;
    end
endmodule : bxd_tb_top
`default_nettype wire
